// >>> shared/spar_pkg.sv
// constants and types shared by the serial port with address recognition
package spar_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] SPAR_OFS_CTRL = 8'h00;
	localparam logic [7:0] SPAR_OFS_BUF  = 8'h04;
	localparam logic [7:0] SPAR_OFS_ADDR = 8'h08;
	localparam logic [7:0] SPAR_OFS_MASK = 8'h0C;
	localparam logic [7:0] SPAR_OFS_PWR  = 8'h10;
	localparam logic [7:0] SPAR_OFS_SEL  = 8'h14;

	// ------------------------------------------------------------
	// field positions and values after reset
	// ------------------------------------------------------------
	localparam int SPAR_B_BIT7 = 7;
	localparam int SPAR_B_SM1  = 6;
	localparam int SPAR_B_SM2  = 5;
	localparam int SPAR_B_REN  = 4;
	localparam int SPAR_B_TB8  = 3;
	localparam int SPAR_B_RB8  = 2;
	localparam int SPAR_B_TI   = 1;
	localparam int SPAR_B_RI   = 0;
	localparam int SPAR_B_DBL  = 7;
	localparam int SPAR_B_FSEL = 6;
	localparam int SPAR_B_RXT2 = 0;
	localparam int SPAR_B_TXT2 = 1;
	localparam logic [7:0] SPAR_RST_BYTE = 8'h00;

	// ------------------------------------------------------------
	// cycle and tick counts
	// ------------------------------------------------------------
	localparam int SPAR_TICKS_PER_BIT = 16;
	localparam int SPAR_M2_DIV        = 64;
	localparam logic [1:0] SPAR_M2_LAST = 2'(SPAR_M2_DIV / SPAR_TICKS_PER_BIT - 1);
	localparam logic [3:0] SPAR_M0_LAST = 4'hB;
	localparam logic [3:0] SPAR_M0_HALF = 4'h6;
	localparam logic [2:0] SPAR_M0_BITS = 3'h7;
	localparam logic [3:0] SPAR_MID     = 4'h7;
	localparam logic [3:0] SPAR_TK_LAST = 4'hF;
	localparam logic [3:0] SPAR_LAST8   = 4'h9;
	localparam logic [3:0] SPAR_LAST9   = 4'hA;
	localparam logic [3:0] SPAR_LEN8    = 4'hA;
	localparam logic [3:0] SPAR_LEN9    = 4'hB;

	typedef enum logic [1:0] {SPAR_SHIFT, SPAR_UART8, SPAR_UART9F, SPAR_UART9V} spar_mode_t;

endpackage

// >>> design/spar_sync.sv
// two-stage synchroniser for the receive pin
`timescale 1ns/1ns
`default_nettype none
module spar_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin and synchronised level
	input  wire logic pinIn,
	output logic      pinSync
);
	logic meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q  <= RST_VAL;
			pinSync <= RST_VAL;
		end else begin
			meta_q  <= pinIn;
			pinSync <= meta_q;
		end
	end
endmodule
`default_nettype wire

// >>> design/spar_baud.sv
// sixteen-times bit tick generator for the asynchronous modes
`timescale 1ns/1ns
`default_nettype none
module spar_baud import spar_pkg::*; (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// configuration
	input  wire spar_mode_t mode,
	input  wire logic       doubler,
	input  wire logic       rxUseT2,
	input  wire logic       txUseT2,
	// timer overflow pulses
	input  wire logic       t1Ovf,
	input  wire logic       t2Ovf,
	// ticks
	output logic            rxTick,
	output logic            txTick
);
	logic [1:0] m2Cnt_q;
	logic       t1Half_q;
	logic       m2Tick;
	logic       t1Tick;

	// fixed rate: 16 ticks per bit means one tick every 4 or 2 clocks
	assign m2Tick = doubler ? m2Cnt_q[0] : (m2Cnt_q == SPAR_M2_LAST);
	// timer1 needs 2 overflows per tick unless doubled
	assign t1Tick = t1Ovf & (doubler | t1Half_q);

	// dividers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			m2Cnt_q  <= 2'h0;
			t1Half_q <= 1'b0;
		end else begin
			m2Cnt_q  <= m2Cnt_q + 2'h1;
			t1Half_q <= t1Half_q ^ t1Ovf;
		end
	end

	// tick select per direction
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxTick <= 1'b0;
			txTick <= 1'b0;
		end else if (mode == SPAR_UART9F) begin
			rxTick <= m2Tick;
			txTick <= m2Tick;
		end else begin
			rxTick <= rxUseT2 ? t2Ovf : t1Tick;
			txTick <= txUseT2 ? t2Ovf : t1Tick;
		end
	end
endmodule
`default_nettype wire

// >>> design/spar_top.sv
// serial port with mode 0 shifter, uart modes and address recognition
//
// How it works
// - mode 3: 11-bit frame, baud from timer1 (doubler/32) or timer2/16
// - any write to the serial buffer starts a transmission; here a write while one is in progress is dropped
// - mode 0 reception starts when receive-done is 0 and enable is 1
// - modes 1-3 reception starts on start-bit falling edge if enabled
// - modes 2/3 with matching on: ninth bit 1 and address match needed
// - mode 1 with matching on: valid stop bit and address match needed
// - mode 0 ignores the matching enable bit
// - missing or low stop bit sets the framing-error flag
// - framing error survives good frames; only a write clears it
// - control bit 7 is framing error if function select set, else mode
// - modes: shifter clk/12, 8-bit var, 9-bit clk/64 or /32, 9-bit var
// - modes 2/3 send tx ninth bit and store received ninth bit
// - reception only while receive enable is set
// - mask selects compared bits of slave address for given address
// - broadcast address is address OR mask, zeros don't care
// - reset clears slave address and mask
// - mode 0: 8 bits lsb first on rx pin, shift clock on tx pin
// - mode 1: 10-bit frame, received stop bit goes to rx ninth bit
// - mode 2: 11-bit frame at doubler/64 of the system clock
// - separate transmit and receive buffers at one address
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module spar_top import spar_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// timer overflow pulses
	input  wire logic        t1Ovf,
	input  wire logic        t2Ovf,
	// serial pins
	input  wire logic        rxdIn,
	output logic             rxdOut,
	output logic             rxdOe_n,
	output logic             txd
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic        sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q;
	logic        ti_q, ri_q, fe_q, dbl_q, fsel_q, rxT2_q, txT2_q;
	logic [7:0]  slave_address_q, slave_address_mask_q, rxBuf_q;
	logic        txBusy_q;
	logic [10:0] txShift_q;
	logic [3:0]  txBits_q, txCnt_q;
	logic        m0Busy_q, m0Tx_q;
	logic [3:0]  m0Phase_q;
	logic [2:0]  m0Bits_q;
	logic [7:0]  m0Shift_q;
	logic        rxBusy_q, rxPrev_q;
	logic [3:0]  rxCnt_q, rxBits_q;
	logic [9:0]  rxShift_q;
	logic        rxd, rxTick, txTick;
	spar_mode_t  mode;
	logic        isShift, is9, access, wrDone;
	logic        wrCtrl, wrBuf, wrAddr, wrMask, wrPwr, wrSel;
	logic        mapped;
	logic [7:0]  rdByte;
	logic        txGoA, txDoneA, m0Go, m0TxGo, m0RxGo, m0Last;
	logic        rxEdge, rxSample, rxFin, rxOk, rxAcceptA;
	logic [7:0]  rxByte;
	logic        rxNinth, txDone, rxAccept, frameErr;

	// given address: mask picks compared bits; broadcast: ones of addr|mask
	function automatic logic addrMatch(input logic [7:0] b, input logic [7:0] a,
		input logic [7:0] m);
		logic [7:0] bc;
		bc = a | m;
		addrMatch = (((b ^ a) & m) == 8'h00) | (((b ^ bc) & bc) == 8'h00);
	endfunction

	// ------------------------------------------------------------
	// mode decode and helpers
	// ------------------------------------------------------------
	assign mode    = spar_mode_t'({sm0_q, sm1_q});
	assign isShift = (mode == SPAR_SHIFT);
	assign is9     = (mode == SPAR_UART9F) | (mode == SPAR_UART9V);

	spar_sync u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pinIn   (rxdIn),
		.pinSync (rxd)
	);

	// mode 2 fixed rate, modes 1 and 3 from timer overflows
	spar_baud u_baud (
		.clk     (clk),
		.rst_n   (rst_n),
		.mode    (mode),
		.doubler (dbl_q),
		.rxUseT2 (rxT2_q),
		.txUseT2 (txT2_q),
		.t1Ovf   (t1Ovf),
		.t2Ovf   (t2Ovf),
		.rxTick  (rxTick),
		.txTick  (txTick)
	);

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	// every access waits one cycle so the answer comes from flops
	assign access = psel & penable;
	assign wrDone = access & pready & pwrite;
	assign wrCtrl = wrDone & (paddr == SPAR_OFS_CTRL);
	assign wrBuf  = wrDone & (paddr == SPAR_OFS_BUF);
	assign wrAddr = wrDone & (paddr == SPAR_OFS_ADDR);
	assign wrMask = wrDone & (paddr == SPAR_OFS_MASK);
	assign wrPwr  = wrDone & (paddr == SPAR_OFS_PWR);
	assign wrSel  = wrDone & (paddr == SPAR_OFS_SEL);

	// read mux; buffer read shows the receive side only
	always_comb begin
		mapped = 1'b1;
		rdByte = 8'h00;
		case (paddr)
			SPAR_OFS_CTRL: rdByte = {fsel_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q,
				tb8_q, rb8_q, ti_q, ri_q};
			SPAR_OFS_BUF:  rdByte = rxBuf_q;
			SPAR_OFS_ADDR: rdByte = slave_address_q;
			SPAR_OFS_MASK: rdByte = slave_address_mask_q;
			SPAR_OFS_PWR:  rdByte = {dbl_q, fsel_q, 6'h00};
			SPAR_OFS_SEL:  rdByte = {6'h00, txT2_q, rxT2_q};
			default:       mapped = 1'b0;
		endcase
	end

	// answer one cycle into the access phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready <= access & !pready;
			if (access & !pready) begin
				pslverr <= !mapped;
				prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
			end
		end
	end

	// ------------------------------------------------------------
	// software control bits
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{sm0_q, sm1_q, sm2_q, ren_q, tb8_q} <= 5'h00;
			{dbl_q, fsel_q, rxT2_q, txT2_q}     <= 4'h0;
			slave_address_q <= SPAR_RST_BYTE;
			slave_address_mask_q <= SPAR_RST_BYTE;
		end else begin
			if (wrCtrl) begin
				if (!fsel_q) begin
					sm0_q <= pwdata[SPAR_B_BIT7];
				end
				sm1_q <= pwdata[SPAR_B_SM1];
				sm2_q <= pwdata[SPAR_B_SM2];
				ren_q <= pwdata[SPAR_B_REN];
				tb8_q <= pwdata[SPAR_B_TB8];
			end
			if (wrPwr) begin
				dbl_q  <= pwdata[SPAR_B_DBL];
				fsel_q <= pwdata[SPAR_B_FSEL];
			end
			if (wrSel) begin
				rxT2_q <= pwdata[SPAR_B_RXT2];
				txT2_q <= pwdata[SPAR_B_TXT2];
			end
			if (wrAddr) begin
				slave_address_q <= pwdata[7:0];
			end
			if (wrMask) begin
				slave_address_mask_q <= pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// hardware flags: a set in the same cycle beats a write
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{ti_q, ri_q, fe_q, rb8_q} <= 4'h0;
			rxBuf_q <= SPAR_RST_BYTE;
		end else begin
			if (txDone) begin
				ti_q <= 1'b1;
			end else if (wrCtrl) begin
				ti_q <= pwdata[SPAR_B_TI];
			end
			if (rxAccept) begin
				ri_q <= 1'b1;
			end else if (wrCtrl) begin
				ri_q <= pwdata[SPAR_B_RI];
			end
			if (frameErr) begin
				fe_q <= 1'b1;
			end else if (wrCtrl & fsel_q) begin
				fe_q <= pwdata[SPAR_B_BIT7];
			end
			if (rxAcceptA) begin
				rb8_q <= rxNinth;
			end else if (wrCtrl) begin
				rb8_q <= pwdata[SPAR_B_RB8];
			end
			if (rxAcceptA) begin
				rxBuf_q <= rxByte;
			end else if (m0RxGo | !m0Last | m0Tx_q) begin
				rxBuf_q <= rxBuf_q;
			end else begin
				rxBuf_q <= {rxd, m0Shift_q[7:1]};
			end
		end
	end

	assign txDone   = txDoneA | (m0Last & m0Tx_q);
	assign rxAccept = rxAcceptA | (m0Last & !m0Tx_q);

	// ------------------------------------------------------------
	// asynchronous transmitter
	// ------------------------------------------------------------
	// a buffer write while a frame is in flight is dropped
	assign txGoA   = wrBuf & !isShift & !txBusy_q;
	assign txDoneA = txBusy_q & txTick & (txCnt_q == SPAR_TK_LAST) & (txBits_q == 4'h1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txBusy_q  <= 1'b0;
			txShift_q <= 11'h7FF;
			txBits_q  <= 4'h0;
			txCnt_q   <= 4'h0;
		end else if (txGoA) begin
			txBusy_q  <= 1'b1;
			txShift_q <= {1'b1, is9 ? tb8_q : 1'b1, pwdata[7:0], 1'b0};
			txBits_q  <= is9 ? SPAR_LEN9 : SPAR_LEN8;
			txCnt_q   <= 4'h0;
		end else if (txBusy_q & txTick) begin
			txCnt_q <= txCnt_q + 4'h1;
			if (txCnt_q == SPAR_TK_LAST) begin
				txShift_q <= {1'b1, txShift_q[10:1]};
				txBits_q  <= txBits_q - 4'h1;
				txBusy_q  <= (txBits_q != 4'h1);
			end
		end
	end

	// ------------------------------------------------------------
	// mode 0 shifter, shared by both directions
	// ------------------------------------------------------------
	assign m0Go   = isShift & !m0Busy_q;
	assign m0TxGo = m0Go & wrBuf;
	assign m0RxGo = m0Go & !wrBuf & !ri_q & ren_q;
	assign m0Last = m0Busy_q & (m0Phase_q == SPAR_M0_LAST) & (m0Bits_q == SPAR_M0_BITS);

	// 12 clocks per bit, data sampled just before the clock falls
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			m0Busy_q  <= 1'b0;
			m0Tx_q    <= 1'b0;
			m0Phase_q <= 4'h0;
			m0Bits_q  <= 3'h0;
			m0Shift_q <= 8'hFF;
		end else if (!isShift) begin
			m0Busy_q <= 1'b0;
		end else if (m0TxGo | m0RxGo) begin
			m0Busy_q  <= 1'b1;
			m0Tx_q    <= m0TxGo;
			m0Phase_q <= 4'h0;
			m0Bits_q  <= 3'h0;
			m0Shift_q <= m0TxGo ? pwdata[7:0] : 8'h00;
		end else if (m0Busy_q) begin
			m0Phase_q <= (m0Phase_q == SPAR_M0_LAST) ? 4'h0 : m0Phase_q + 4'h1;
			if (m0Phase_q == SPAR_M0_LAST) begin
				m0Shift_q <= {m0Tx_q | rxd, m0Shift_q[7:1]};
				m0Bits_q  <= m0Bits_q + 3'h1;
				m0Busy_q  <= (m0Bits_q != SPAR_M0_BITS);
			end
		end
	end

	// ------------------------------------------------------------
	// asynchronous receiver
	// ------------------------------------------------------------
	assign rxEdge    = rxPrev_q & !rxd;
	assign rxSample  = rxBusy_q & rxTick & (rxCnt_q == SPAR_MID);
	assign rxFin     = rxSample & (rxBits_q == (is9 ? SPAR_LAST9 : SPAR_LAST8));
	assign rxByte    = is9 ? rxShift_q[8:1] : rxShift_q[9:2];
	assign rxNinth   = is9 ? rxShift_q[9] : rxd;
	assign rxOk      = rxNinth & addrMatch(rxByte, slave_address_q, slave_address_mask_q);
	assign rxAcceptA = rxFin & !ri_q & (!sm2_q | rxOk);
	assign frameErr  = rxFin & !rxd;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxPrev_q  <= 1'b1;
			rxBusy_q  <= 1'b0;
			rxCnt_q   <= 4'h0;
			rxBits_q  <= 4'h0;
			rxShift_q <= 10'h000;
		end else begin
			rxPrev_q <= rxd;
			if (!ren_q | isShift) begin
				rxBusy_q <= 1'b0;
			end else if (!rxBusy_q) begin
				if (rxEdge) begin
					rxBusy_q <= 1'b1;
					rxCnt_q  <= 4'h0;
					rxBits_q <= 4'h0;
				end
			end else if (rxTick) begin
				rxCnt_q <= rxCnt_q + 4'h1;
				if (rxCnt_q == SPAR_MID) begin
					rxShift_q <= {rxd, rxShift_q[9:1]};
					rxBits_q  <= rxBits_q + 4'h1;
					// a start bit high again at mid-bit was noise
					if (((rxBits_q == 4'h0) & rxd) | rxFin) begin
						rxBusy_q <= 1'b0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txd     <= 1'b1;
			rxdOut  <= 1'b1;
			rxdOe_n <= 1'b1;
		end else begin
			txd     <= isShift ? !(m0Busy_q & (m0Phase_q < SPAR_M0_HALF))
				: (!txBusy_q | txShift_q[0]);
			rxdOut  <= !(m0Busy_q & m0Tx_q) | m0Shift_q[0];
			rxdOe_n <= !(isShift & m0Busy_q & m0Tx_q);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	tx_start_a: assert property (txGoA |=> ##1 !txd)
		else $error("start bit not sent after buffer write");
	m0_start_a: assert property (m0RxGo |=> m0Busy_q && !m0Tx_q)
		else $error("mode 0 reception did not start");
	rx_gate_a: assert property (!ren_q |=> !rxBusy_q)
		else $error("receiver busy while disabled");
	addr9_filter_a: assert property (rxFin && is9 && sm2_q && !rxShift_q[9]
		|-> !rxAcceptA)
		else $error("data byte accepted with matching on");
	addr8_filter_a: assert property (rxFin && !is9 && sm2_q && !rxd
		|-> !rxAcceptA)
		else $error("bad stop accepted with matching on");
	fe_set_a: assert property (rxFin && !rxd |=> fe_q)
		else $error("framing error not flagged");
	fe_hold_a: assert property (fe_q && !(wrCtrl && fsel_q) |=> fe_q)
		else $error("framing error cleared without write");
	bit7_read_a: assert property (access && !pready && !pwrite
		&& paddr == SPAR_OFS_CTRL |=> prdata[7] == $past(fsel_q ? fe_q : sm0_q))
		else $error("control bit 7 read wrong source");
	addr_reset_a: assert property ($rose(rst_n) |-> slave_address_q == 8'h00
		&& slave_address_mask_q == 8'h00)
		else $error("address registers not cleared");
	m0_clock_a: assert property (isShift && m0Busy_q && m0Phase_q == 4'h0
		|=> !txd ##6 txd)
		else $error("mode 0 shift clock shape wrong");
	tx_ninth_a: assert property (txGoA && is9 |=> txShift_q[9] == $past(tb8_q))
		else $error("ninth bit not loaded");

	tx_done_c: cover property (txDoneA);
	rx_accept_c: cover property (rxAcceptA && sm2_q);
	frame_err_c: cover property (frameErr);
	m0_rx_c: cover property (m0Last && !m0Tx_q);
endmodule
`default_nettype wire

// >>> verif/spar_node.sv
// remote serial node model facing the serial port pins
`timescale 1ns/1ns
`default_nettype none
module spar_node (
	// clock
	input  wire logic clk,
	// device pins
	input  wire logic txd,
	input  wire logic rxdOut,
	input  wire logic rxdOe_n,
	// resolved receive line
	output logic      rxdIn
);
	logic        drv    = 1'h1;
	logic        m0     = 1'h0;
	logic [10:0] got    = 11'h000;
	logic [7:0]  m0Got  = 8'h00;
	logic [7:0]  m0Tx   = 8'h00;
	int          per    = 64;
	int          nb     = 11;
	int          frames = 0;
	int          rises  = 0;
	int          m0Per  = 0;
	time         lastUp = 0;

	// pulled-up line; the device wins only while its enable is low
	assign rxdIn = rxdOe_n ? drv : rxdOut;

	// async frame out, start bit first, data lsb first
	task automatic send(input logic [10:0] fr, input int n);
		for (int i = 0; i < n; i++) begin
			drv <= fr[i];
			repeat (per) @(posedge clk);
		end
		drv <= 1'h1;
	endtask

	// mode 0 preload: first bit must sit on the line before the first sample
	task automatic m0Load(input logic [7:0] dv);
		m0Tx = dv;
		rises = 0;
		drv <= dv[0];
	endtask

	// async monitor, mid-bit sampling timed from the start edge
	always begin
		@(negedge txd);
		if (!m0) begin
			got = 11'h000;
			repeat (per / 2) @(posedge clk);
			for (int i = 0; i < nb; i++) begin
				got[i] = txd;
				if (i == nb - 1) frames++;
				else repeat (per) @(posedge clk);
			end
		end
	end

	// mode 0: take data on the shift clock rise and time its period
	always @(posedge txd) begin
		if (m0) begin
			m0Got <= {rxdIn, m0Got[7:1]};
			rises <= rises + 1;
			m0Per <= int'(($time - lastUp) / 10);
			lastUp <= $time;
		end
	end

	// mode 0: next bit goes out on the fall, well before the device samples
	always @(negedge txd) begin
		if (m0 && rises < 8) drv <= m0Tx[rises[2:0]];
	end

	// a released line floats back to its pull-up level
	always @(posedge rxdOe_n) begin
		drv <= 1'h1;
	end
endmodule
`default_nettype wire

// >>> verif/spar_top_tb.sv
// self-checking bench for the serial port with address recognition
`timescale 1ns/1ns
`default_nettype none
module spar_top_tb import spar_pkg::*; ;
	logic        clk     = 1'h0;
	logic        rst_n   = 1'h0;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        t1Ovf   = 1'h0;
	logic        t2Ovf   = 1'h0;
	logic [1:0]  tc      = 2'h0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, rxdIn, rxdOut, rxdOe_n, txd, e;
	logic [7:0]  d;
	int          err_total   = 0;
	int          checks_done = 0;
	int          f;
	logic [7:0]  txCtrl [5] = '{8'h88, 8'h80, 8'h40, 8'h40, 8'hC8};
	logic [7:0]  txPwr  [5] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
	logic [7:0]  txSel  [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
	int          txPer  [5] = '{64, 32, 64, 32, 64};
	logic [7:0]  rxCtrl [8] = '{8'hB0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hE0, 8'h70, 8'h70};
	logic [7:0]  rxDat  [8] = '{8'h53, 8'h53, 8'h53, 8'h35, 8'hFE, 8'h53, 8'h53, 8'h53};
	logic        rxNin  [8] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
	logic        rxOk   [8] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};

	spar_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .t1Ovf(t1Ovf), .t2Ovf(t2Ovf),
		.rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe_n(rxdOe_n), .txd(txd));
	spar_node node (.clk(clk), .txd(txd), .rxdOut(rxdOut), .rxdOe_n(rxdOe_n), .rxdIn(rxdIn));

	// 100 MHz clock
	initial forever #5 clk = ~clk;

	// timer overflows: timer1 every 2 clocks, timer2 every 4
	always @(posedge clk) begin
		tc <= tc + 2'h1;
		t1Ovf <= tc[0];
		t2Ovf <= (tc == 2'h3);
	end

	// ------------------------------------------------------------
	// bus and compare helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		output logic [31:0] rd, output logic er);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'h1;
		// no cycle count assumed: only the watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] y;
		logic x;
		apb(1'h1, a, v, y, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		logic x;
		apb(1'h0, a, 8'h00, v, x);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		check(v, exp);
	endtask

	// poll a control flag with a bound on the wait
	task automatic waitFlag(input int b);
		logic [31:0] v;
		int n;
		n = 0;
		do begin
			rd(SPAR_OFS_CTRL, v);
			n++;
		end while (v[b] !== 1'h1 && n < 400);
		check(v[b], 1'h1);
	endtask

	task automatic give_verdict();
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard, well past the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		rdChk(SPAR_OFS_ADDR, 32'h0);
		rdChk(SPAR_OFS_MASK, 32'h0);
		apb(1'h0, 8'h18, 8'h00, r, e);
		check(e, 1'h1);
		check(r, 32'h0);
		// async transmit in modes 1 to 3, both clock sources, doubler on and off
		for (int i = 0; i < 5; i++) begin
			d = 8'hA5 ^ 8'(i);
			wr(SPAR_OFS_PWR, txPwr[i]);
			wr(SPAR_OFS_SEL, txSel[i]);
			wr(SPAR_OFS_CTRL, txCtrl[i]);
			node.per = txPer[i];
			node.nb = txCtrl[i][7] ? 11 : 10;
			f = node.frames;
			wr(SPAR_OFS_BUF, d);
			waitFlag(1);
			check(node.frames, f + 1);
			check(node.got, txCtrl[i][7] ? {1'h1, txCtrl[i][3], d, 1'h0}
				: {2'h1, d, 1'h0});
		end
		// receive side: given 0101xxxx, broadcast 1111_1x1x
		wr(SPAR_OFS_ADDR, 8'h5A);
		wr(SPAR_OFS_MASK, 8'hF0);
		wr(SPAR_OFS_SEL, 8'h01);
		wr(SPAR_OFS_PWR, 8'h00);
		wr(SPAR_OFS_CTRL, 8'hF0);
		node.per = 16;
		node.send(11'h7FE, 1);
		node.per = 64;
		repeat (800) @(posedge clk);
		rd(SPAR_OFS_CTRL, r);
		check(r[0], 1'h0);
		for (int i = 0; i < 8; i++) begin
			wr(SPAR_OFS_CTRL, rxCtrl[i]);
			node.send({1'h1, rxNin[i], rxDat[i], 1'h0}, rxCtrl[i][7] ? 11 : 10);
			repeat (8) @(posedge clk);
			rd(SPAR_OFS_CTRL, r);
			check(r[0], rxOk[i]);
			if (rxOk[i]) begin
				check(r[2], rxNin[i]);
				rdChk(SPAR_OFS_BUF, {24'h000000, rxDat[i]});
			end
		end
		// a transmit write must leave the received byte readable
		node.nb = 10;
		f = node.frames;
		wr(SPAR_OFS_BUF, 8'hC3);
		rdChk(SPAR_OFS_BUF, 32'h00000053);
		waitFlag(1);
		check(node.frames, f + 1);
		check(node.got, {2'h1, 8'hC3, 1'h0});
		// framing error kept through a good frame, shared bit 7
		rd(SPAR_OFS_CTRL, r);
		check(r[7], 1'h0);
		wr(SPAR_OFS_PWR, 8'h40);
		rd(SPAR_OFS_CTRL, r);
		check(r[7], 1'h1);
		wr(SPAR_OFS_CTRL, 8'h70);
		rd(SPAR_OFS_CTRL, r);
		check(r[7], 1'h0);
		wr(SPAR_OFS_PWR, 8'h00);
		// mode 0 transmit, then receive with matching enable set
		node.m0 = 1'h1;
		wr(SPAR_OFS_CTRL, 8'h00);
		wr(SPAR_OFS_BUF, 8'h3C);
		waitFlag(1);
		check(node.m0Got, 8'h3C);
		check(node.m0Per, 12);
		node.m0Load(8'hC5);
		wr(SPAR_OFS_CTRL, 8'h30);
		waitFlag(0);
		wr(SPAR_OFS_CTRL, 8'h00);
		rdChk(SPAR_OFS_BUF, 32'h000000C5);
		give_verdict();
	end
endmodule
`default_nettype wire
